// [hdl/acr_pkg.sv]
// Shared constants and types of the auxiliary control register block.
// Assumes one 25 MHz core clock that also stands for the oscillator.
package acr_pkg;

  // Register map
  localparam logic [7:0] AUX_CONTROL_ADDR = 8'h8e;
  localparam logic [7:0] AUX_CONTROL_RESET = 8'h0c;
  // Bits 6 and 4 are never stored
  localparam logic [7:0] AUX_CONTROL_WMASK = 8'haf;
  localparam logic [7:0] READ_IDLE = 8'h00;

  // Field positions
  localparam int BIT_PULLUP_DISABLE = 7;
  localparam int BIT_STROBE_STRETCH = 5;
  localparam int BIT_RAM_SIZE_HI = 3;
  localparam int BIT_RAM_SIZE_LO = 2;
  localparam int BIT_EXT_RAM_SELECT = 1;
  localparam int BIT_STROBE_SUPPRESS = 0;

  // Strobe rate dividers, in oscillator periods
  localparam int DIV_W = 3;
  localparam logic [DIV_W-1:0] STROBE_DIV_NORMAL = 3'h6;
  localparam logic [DIV_W-1:0] STROBE_DIV_DOUBLE = 3'h3;

  // Read and write pulse widths, in clock periods
  localparam int PULSE_W = 5;
  localparam logic [PULSE_W-1:0] PULSE_SHORT = 5'h06;
  localparam logic [PULSE_W-1:0] PULSE_LONG = 5'h1e;

  // Expanded RAM size is (field + 1) pages of 256 bytes
  localparam int RAM_SIZE_W = 11;
  localparam int RAM_PAGE_SHIFT = 8;

  localparam int ADDR_W = 16;

  typedef struct packed {
    logic pullup_disable;
    logic rsvd6;
    logic strobe_stretch;
    logic rsvd4;
    logic ram_size_hi;
    logic ram_size_lo;
    logic external_ram_select;
    logic strobe_suppress;
  } acr_aux_t;

  typedef struct packed {
    logic write;
    logic [ADDR_W-1:0] addr;
  } acr_xreq_t;

  typedef enum logic [1:0] {
    XS_IDLE,
    XS_EXTERNAL
  } acr_xstate_t;

endpackage : acr_pkg

// [hdl/acr_rate_div.sv]
// Machine-rate divider: one-cycle tick every 6 clocks, or 3 in double speed.
// Assumes the speed select is stable or changes only between ticks.
`timescale 1ns/1ps
module acr_rate_div (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Control
  input wire logic double_speed_mode,
  // Tick
  output logic tick
);

  logic [acr_pkg::DIV_W-1:0] count_reg;
  logic [acr_pkg::DIV_W-1:0] limit;

  assign limit = double_speed_mode ? acr_pkg::STROBE_DIV_DOUBLE : acr_pkg::STROBE_DIV_NORMAL;
  assign tick = (count_reg >= limit - 3'h1);

  // Wraps early if double speed is selected mid-period
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      count_reg <= 3'h0;
    end else if (tick) begin
      count_reg <= 3'h0;
    end else begin
      count_reg <= count_reg + 3'h1;
    end
  end

endmodule : acr_rate_div

// [hdl/acr_pulse_timer.sv]
// Down-counter that holds a level for a loaded number of clocks.
// Assumes start is not raised while the level is still active.
`timescale 1ns/1ps
module acr_pulse_timer #(
  parameter int W = 5
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Load
  input wire logic start,
  input wire logic [W-1:0] length,
  // Status
  output logic active
);

  logic [W-1:0] count_reg;

  assign active = (count_reg != '0);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      count_reg <= '0;
    end else if (start) begin
      count_reg <= length;
    end else if (active) begin
      count_reg <= count_reg - 1'b1;
    end
  end

endmodule : acr_pulse_timer

// [hdl/acr_aux_control.sv]
// Auxiliary control register and the bus-control logic that it steers.
// Assumes a core that raises one data move at a time and reads the register
// port synchronously; pads turn strobe_oe low into a weak pull-up.
//
// Summary of operation
// R1: Address strobe marks every external memory access
// R2: Unsuppressed strobe runs at clock/6, or clock/3
// R3: Suppressed strobe only during external accesses
// R4: Suppressed strobe pin is released to pull-up
// R5: Bit 7 set removes port weak pull-ups
// R6: Bit 5 stretches read/write pulses 6 to 30
// R7: Bits 3:2 size expanded RAM, 256 to 1024
// R8: Bit 1 sends data moves to external memory
// R9: Bits 6 and 4 reserved, never written one
// R10: Resets to 0x0c, whole-byte access only
// R11: New settings act from next machine cycle
//
// Design decision made here: the address-and-strobe port.
`timescale 1ns/1ps
module acr_aux_control (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_we,
  input wire logic reg_re,
  output logic [7:0] reg_rdata,
  // Core side
  input wire logic double_speed_mode,
  input wire logic ext_fetch,
  input wire logic code_table_read,
  input wire logic xmove_valid,
  input wire acr_pkg::acr_xreq_t xmove_req,
  output logic xmove_busy,
  output logic internal_ram_sel,
  output logic [acr_pkg::ADDR_W-1:0] internal_ram_addr,
  output logic machine_tick,
  // External bus pins
  output logic strobe_o,
  output logic strobe_oe,
  output logic read_n,
  output logic write_n,
  output logic [acr_pkg::ADDR_W-1:0] bus_addr,
  // Port and memory configuration
  output logic pullup_enable,
  output logic [acr_pkg::RAM_SIZE_W-1:0] ram_size_bytes
);

  ////////////////////////////////////////////////////////////////////////////
  // Register and its applied copy

  acr_pkg::acr_aux_t aux_reg;
  acr_pkg::acr_aux_t active_reg;
  logic [7:0] rdata_reg;
  logic hit;
  logic tick;

  assign hit = (reg_addr == acr_pkg::AUX_CONTROL_ADDR);

  // Whole-byte write; reserved bits are dropped
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      aux_reg <= acr_pkg::AUX_CONTROL_RESET; // [R10]
    end else if (reg_we && hit) begin
      aux_reg <= reg_wdata & acr_pkg::AUX_CONTROL_WMASK; // [R9] [R10]
    end
  end

  // Bus logic sees changes only at a machine-cycle boundary
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      active_reg <= acr_pkg::AUX_CONTROL_RESET;
    end else if (tick) begin
      active_reg <= aux_reg; // [R11]
    end
  end

  // Reserved bits read as zero; unmapped reads return zero
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdata_reg <= acr_pkg::READ_IDLE;
    end else if (reg_re && hit) begin
      rdata_reg <= aux_reg & acr_pkg::AUX_CONTROL_WMASK; // [R9]
    end else begin
      rdata_reg <= acr_pkg::READ_IDLE;
    end
  end

  assign reg_rdata = rdata_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Configuration outputs

  logic pullup_enable_reg;
  logic [acr_pkg::RAM_SIZE_W-1:0] ram_size_reg;
  logic [acr_pkg::RAM_SIZE_W-1:0] ram_size_next;

  assign ram_size_next = {{(acr_pkg::RAM_SIZE_W - 2){1'b0}},
                          active_reg.ram_size_hi, active_reg.ram_size_lo}
                         + {{(acr_pkg::RAM_SIZE_W - 1){1'b0}}, 1'b1};

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pullup_enable_reg <= 1'b1;
      ram_size_reg <= '0;
    end else begin
      pullup_enable_reg <= !active_reg.pullup_disable; // [R5]
      ram_size_reg <= ram_size_next << acr_pkg::RAM_PAGE_SHIFT; // [R7]
    end
  end

  assign pullup_enable = pullup_enable_reg;
  assign ram_size_bytes = ram_size_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Machine rate

  acr_rate_div u_rate (
    .clk(clk),
    .rst(rst),
    .double_speed_mode(double_speed_mode),
    .tick(tick)
  );

  assign machine_tick = tick;

  ////////////////////////////////////////////////////////////////////////////
  // Data move routing and read/write strobes

  acr_pkg::acr_xstate_t xstate_reg;
  logic xwrite_reg;
  logic stretch_lat_reg;
  logic [acr_pkg::ADDR_W-1:0] xaddr_reg;
  logic int_sel_reg;
  logic go_external;
  logic accept;
  logic timer_start;
  logic timer_active;
  logic [acr_pkg::PULSE_W-1:0] pulse_len;
  logic [acr_pkg::ADDR_W-1:0] size_ext;

  assign size_ext = {{(acr_pkg::ADDR_W - acr_pkg::RAM_SIZE_W){1'b0}}, ram_size_next}
                    << acr_pkg::RAM_PAGE_SHIFT;
  assign accept = xmove_valid && (xstate_reg == acr_pkg::XS_IDLE);
  // Beyond the expanded RAM the move falls through to external memory
  assign go_external = active_reg.external_ram_select || (xmove_req.addr >= size_ext); // [R7] [R8]
  assign timer_start = accept && go_external;
  assign pulse_len = active_reg.strobe_stretch ? acr_pkg::PULSE_LONG
                                               : acr_pkg::PULSE_SHORT; // [R6]

  acr_pulse_timer #(
    .W(acr_pkg::PULSE_W)
  ) u_pulse (
    .clk(clk),
    .rst(rst),
    .start(timer_start),
    .length(pulse_len),
    .active(timer_active)
  );

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      xstate_reg <= acr_pkg::XS_IDLE;
    end else begin
      case (xstate_reg)
        acr_pkg::XS_IDLE: begin
          if (timer_start) begin
            xstate_reg <= acr_pkg::XS_EXTERNAL;
          end
        end
        acr_pkg::XS_EXTERNAL: begin
          if (!timer_active && !timer_start) begin
            xstate_reg <= acr_pkg::XS_IDLE;
          end
        end
        default: begin
          xstate_reg <= acr_pkg::XS_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      xwrite_reg <= 1'b0;
      stretch_lat_reg <= 1'b0;
      xaddr_reg <= '0;
    end else if (accept) begin
      xwrite_reg <= xmove_req.write;
      stretch_lat_reg <= active_reg.strobe_stretch;
      xaddr_reg <= xmove_req.addr;
    end
  end

  // Internal hits complete in the cycle after acceptance
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      int_sel_reg <= 1'b0;
    end else begin
      int_sel_reg <= accept && !go_external; // [R8]
    end
  end

  assign internal_ram_sel = int_sel_reg;
  assign internal_ram_addr = xaddr_reg;
  assign bus_addr = xaddr_reg;
  assign xmove_busy = (xstate_reg != acr_pkg::XS_IDLE) || int_sel_reg;
  assign read_n = !(timer_active && !xwrite_reg); // [R6]
  assign write_n = !(timer_active && xwrite_reg); // [R6]

  ////////////////////////////////////////////////////////////////////////////
  // Address latch strobe

  logic ext_active;
  logic emit;
  logic strobe_reg;
  logic strobe_oe_reg;

  assign ext_active = ext_fetch || code_table_read || (xstate_reg == acr_pkg::XS_EXTERNAL);
  assign emit = !active_reg.strobe_suppress || ext_active; // [R1] [R3]

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      strobe_reg <= 1'b0;
      strobe_oe_reg <= 1'b1;
    end else begin
      strobe_reg <= tick && emit; // [R2] [R3]
      // Released pin floats to the weak pull-up, cutting emission
      strobe_oe_reg <= emit; // [R4]
    end
  end

  assign strobe_o = strobe_reg;
  assign strobe_oe = strobe_oe_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  logic first_reg;
  logic [acr_pkg::PULSE_W:0] low_len_reg;
  logic strobe_idle;

  assign strobe_idle = read_n && write_n;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      first_reg <= 1'b1;
      low_len_reg <= '0;
    end else begin
      first_reg <= 1'b0;
      low_len_reg <= strobe_idle ? '0 : low_len_reg + 1'b1;
    end
  end

  property p_ext_strobe;
    @(posedge clk) disable iff (rst) ext_active && tick |=> strobe_o && strobe_oe;
  endproperty
  a_ext_strobe: assert property (p_ext_strobe) else $error("no strobe in ext access"); // [R1]

  property p_rate_normal;
    @(posedge clk) disable iff (rst)
      strobe_o && !active_reg.strobe_suppress && !double_speed_mode
      |=> !strobe_o [*5] ##1 (strobe_o || active_reg.strobe_suppress || double_speed_mode);
  endproperty
  a_rate_normal: assert property (p_rate_normal) else $error("strobe rate not 1/6"); // [R2]

  property p_suppressed;
    @(posedge clk) disable iff (rst)
      active_reg.strobe_suppress && !ext_active |=> !strobe_o;
  endproperty
  a_suppressed: assert property (p_suppressed) else $error("strobe while suppressed"); // [R3]

  // Pin must be released whenever the strobe is suppressed and no access runs
  property p_released;
    @(posedge clk) disable iff (rst)
      active_reg.strobe_suppress && !ext_active |=> !strobe_oe;
  endproperty
  a_released: assert property (p_released) else $error("strobe pin drive wrong"); // [R4]

  property p_pullup;
    @(posedge clk) disable iff (rst)
      reg_we && hit && reg_wdata[acr_pkg::BIT_PULLUP_DISABLE] |-> ##[1:8] !pullup_enable;
  endproperty
  a_pullup: assert property (p_pullup) else $error("pull-ups not removed"); // [R5]

  property p_width;
    @(posedge clk) disable iff (rst)
      $rose(strobe_idle) |->
        low_len_reg == {1'b0, (stretch_lat_reg ? acr_pkg::PULSE_LONG : acr_pkg::PULSE_SHORT)};
  endproperty
  a_width: assert property (p_width) else $error("rd/wr pulse width wrong"); // [R6]

  property p_internal;
    @(posedge clk) disable iff (rst)
      accept && !active_reg.external_ram_select && xmove_req.addr < size_ext
      |=> internal_ram_sel && strobe_idle;
  endproperty
  a_internal: assert property (p_internal) else $error("internal move misrouted"); // [R7]

  property p_external;
    @(posedge clk) disable iff (rst)
      accept && active_reg.external_ram_select |=> !internal_ram_sel && !strobe_idle;
  endproperty
  a_external: assert property (p_external) else $error("external move misrouted"); // [R8]

  property p_reserved;
    @(posedge clk) disable iff (rst)
      reg_re && hit |=> reg_rdata[6] == 1'b0 && reg_rdata[4] == 1'b0;
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved bit reads one"); // [R9]

  property p_reset_value;
    @(posedge clk) disable iff (rst)
      first_reg |-> aux_reg == acr_pkg::AUX_CONTROL_RESET;
  endproperty
  a_reset_value: assert property (p_reset_value) else $error("bad reset value"); // [R10]

  property p_apply;
    @(posedge clk) disable iff (rst)
      !tick |=> $stable(active_reg);
  endproperty
  a_apply: assert property (p_apply) else $error("setting applied off boundary"); // [R11]

  property p_apply_tick;
    @(posedge clk) disable iff (rst)
      tick |=> active_reg == $past(aux_reg);
  endproperty
  a_apply_tick: assert property (p_apply_tick) else $error("setting not applied"); // [R11]

  c_suppress: cover property (@(posedge clk) disable iff (rst)
    active_reg.strobe_suppress && ext_active && strobe_o);
  c_long_read: cover property (@(posedge clk) disable iff (rst)
    $rose(strobe_idle) && stretch_lat_reg);
  c_internal: cover property (@(posedge clk) disable iff (rst) internal_ram_sel);
  c_double: cover property (@(posedge clk) disable iff (rst) double_speed_mode && strobe_o);

endmodule : acr_aux_control

// [testbench/acr_ext_mem.sv]
// External memory model on the multiplexed bus.
// Assumes active-low read and write pulses with a latched address.
`timescale 1ns/1ps
module acr_ext_mem (
  // Clock
  input wire logic clk,
  // Bus pins
  input wire logic read_n,
  input wire logic write_n,
  input wire logic [15:0] bus_addr,
  input wire logic strobe_o,
  input wire logic strobe_oe,
  // Observed access
  output logic done,
  output logic [20:0] seen,
  output logic strobe_pin
);
  logic [4:0] len = 5'h00;

  initial done = 1'b0;
  initial seen = 21'h0;

  // Released pin floats to the weak pull-up level
  assign strobe_pin = strobe_oe ? strobe_o : 1'b1;

  // Pulse width and address are recorded as one note per access
  always @(posedge clk) begin
    done <= 1'b0;
    if (!read_n || !write_n) begin
      len <= len + 5'h01;
      seen <= {len + 5'h01, bus_addr};
    end else if (len != 5'h00) begin
      done <= 1'b1;
      len <= 5'h00;
    end
  end
endmodule : acr_ext_mem

// [testbench/acr_aux_control_test.sv]
// Self-checking bench for the auxiliary control register block.
// Assumes the external memory model acr_ext_mem.
`timescale 1ns/1ps
module acr_aux_control_test;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_we = 1'b0;
  logic reg_re = 1'b0;
  logic double_speed_mode = 1'b0;
  logic ext_fetch = 1'b0;
  logic code_table_read = 1'b0;
  logic xmove_valid = 1'b0;
  acr_pkg::acr_xreq_t xmove_req = '0;
  logic [7:0] reg_rdata;
  logic xmove_busy, internal_ram_sel, machine_tick, strobe_o, strobe_oe;
  logic read_n, write_n, pullup_enable, done, strobe_pin;
  logic rflag = 1'b0;
  logic [15:0] internal_ram_addr, bus_addr;
  logic [10:0] ram_size_bytes;
  logic [20:0] seen;
  logic [31:0] rq[$];
  logic [31:0] mq[$];
  logic [7:0] v;
  int num_errors = 0;
  int checked = 0;
  int seed = 70498;
  int c, i, t;

  always #20 clk = ~clk;

  acr_aux_control i_acr_aux_control (.clk(clk), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_we(reg_we), .reg_re(reg_re), .reg_rdata(reg_rdata),
    .double_speed_mode(double_speed_mode), .ext_fetch(ext_fetch),
    .code_table_read(code_table_read), .xmove_valid(xmove_valid), .xmove_req(xmove_req),
    .xmove_busy(xmove_busy), .internal_ram_sel(internal_ram_sel),
    .internal_ram_addr(internal_ram_addr), .machine_tick(machine_tick),
    .strobe_o(strobe_o), .strobe_oe(strobe_oe), .read_n(read_n), .write_n(write_n),
    .bus_addr(bus_addr), .pullup_enable(pullup_enable), .ram_size_bytes(ram_size_bytes));

  acr_ext_mem i_acr_ext_mem (.clk(clk), .read_n(read_n), .write_n(write_n),
    .bus_addr(bus_addr), .strobe_o(strobe_o), .strobe_oe(strobe_oe), .done(done),
    .seen(seen), .strobe_pin(strobe_pin));

  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  task automatic close_out;
    $display("errors %0d checks %0d", num_errors, checked);
    if (num_errors == 0 && checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : close_out

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_we <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_we <= 1'b0;
    // Settings act from the next machine cycle
    repeat (14) @(posedge clk);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    rq.push_back({24'h0, exp});
    @(posedge clk);
    reg_re <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_re <= 1'b0;
  endtask : rd

  task automatic move(input logic w, input logic [15:0] a, input logic [31:0] exp);
    int n;
    mq.push_back(exp);
    @(posedge clk);
    xmove_valid <= 1'b1;
    xmove_req.write <= w;
    xmove_req.addr <= a;
    @(posedge clk);
    xmove_valid <= 1'b0;
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (xmove_busy !== 1'b0 && n < 60);
    if (n >= 60) begin
      num_errors++;
      close_out();
    end
    @(posedge clk);
  endtask : move

  task automatic count_strobes(input int cyc, output int n, output int tk);
    n = 0;
    tk = 0;
    repeat (cyc) begin
      @(negedge clk);
      if (strobe_o === 1'b1 && strobe_oe === 1'b1)
        n++;
      if (machine_tick === 1'b1)
        tk++;
    end
  endtask : count_strobes

  // Speed changes land on a tick edge so no period is cut short
  task automatic align_tick;
    int n;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (machine_tick !== 1'b1 && n < 8);
    if (n >= 8) begin
      num_errors++;
      close_out();
    end
  endtask : align_tick

  ////////////////////////////////////////////////////////////////////////////
  // Watcher: read data one cycle after the strobe, moves at their result
  always @(negedge clk) begin
    if (rflag) begin
      if (rq.size() == 0)
        chk("read_note", 32'h1, 32'h0);
      else
        chk("reg_rdata", {24'h0, reg_rdata}, rq.pop_front());
    end
    rflag = reg_re;
    if (internal_ram_sel === 1'b1 || done === 1'b1) begin
      if (mq.size() == 0)
        chk("move_note", 32'h1, 32'h0);
      else
        chk("move", internal_ram_sel ? {16'h0, internal_ram_addr} : {11'h0, seen},
          mq.pop_front());
    end
  end

  // Hang guard
  initial begin
    repeat (20000) @(posedge clk);
    num_errors++;
    close_out();
  end

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
    @(negedge clk);
    chk("pullup_enable", pullup_enable, 1'b1);
    chk("ram_size_bytes", ram_size_bytes, 32'h400);
    rd(8'h8e, 8'h0c);
    rd(8'h8f, 8'h00);
    for (i = 0; i < 2; i++) begin
      align_tick();
      double_speed_mode <= i[0];
      repeat (12) @(posedge clk);
      count_strobes(60, c, t);
      chk("strobe_rate", c, i ? 32'h14 : 32'h0a);
      chk("machine_tick", t, i ? 32'h14 : 32'h0a);
    end
    align_tick();
    double_speed_mode <= 1'b0;
    // Reserved bits kept clear, bits 5, 1 and 0 random
    for (i = 0; i < 4; i++) begin
      v = 8'($random(seed)) & 8'ha3;
      v[3:2] = i[1:0];
      // Both pull-up settings are visited whatever the seed gives
      v[7] = i[0];
      wr(8'h8e, v);
      rd(8'h8e, v);
      @(negedge clk);
      chk("ram_size_bytes", ram_size_bytes, (i + 1) * 32'h100);
      chk("pullup_enable", pullup_enable, !v[7]);
    end
    for (i = 0; i < 2; i++) begin
      wr(8'h8e, i ? 8'h2e : 8'h0e);
      v = 8'($random(seed));
      move(1'b0, {8'h12, v}, {11'h0, i ? 5'h1e : 5'h06, 8'h12, v});
      move(1'b1, {8'h34, v}, {11'h0, i ? 5'h1e : 5'h06, 8'h34, v});
    end
    // Boundary of the smallest and largest RAM sizes
    wr(8'h8e, 8'h00);
    move(1'b0, 16'h00ff, 32'h000000ff);
    move(1'b1, 16'h0100, {11'h0, 5'h06, 16'h0100});
    wr(8'h8e, 8'h0c);
    move(1'b1, 16'h03ff, 32'h000003ff);
    wr(8'h8e, 8'h0d);
    for (i = 0; i < 3; i++) begin
      @(posedge clk);
      {code_table_read, ext_fetch} <= i[1:0];
      repeat (14) @(posedge clk);
      count_strobes(60, c, t);
      chk("strobe_count", c, i ? 32'h0a : 32'h0);
      chk("machine_tick", t, 32'h0a);
      if (i == 0)
        chk("strobe_oe", strobe_oe, 1'b0);
      if (i == 0)
        chk("strobe_pin", strobe_pin, 1'b1);
    end
    @(posedge clk);
    {code_table_read, ext_fetch} <= 2'h0;
    repeat (4) @(posedge clk);
    close_out();
  end
endmodule : acr_aux_control_test
